// >>> inc/ledi_pkg.sv
// Constants, register map and carrier types of the LED indicator block.
// Assumes a 50 MHz core clock shared by the block and its status sources.
`default_nettype none
package ledi_pkg;
    // Clock and timing
    localparam int LEDI_CLK_HZ = 50_000_000;
    localparam int LEDI_MS_PER_S = 1000;
    localparam int LEDI_HOLD_MS = 10;
    localparam int LEDI_HOLD_CYC = LEDI_CLK_HZ / LEDI_MS_PER_S * LEDI_HOLD_MS;
    localparam int LEDI_FAST_HZ = 16;
    localparam int LEDI_SLOW_HZ = 2;
    localparam int LEDI_SLOTS_N = 12;
    localparam int LEDI_TICK_CYC = LEDI_CLK_HZ / (LEDI_FAST_HZ * LEDI_SLOTS_N);
    localparam int LEDI_PHASE_N = LEDI_SLOTS_N * LEDI_FAST_HZ / LEDI_SLOW_HZ;
    localparam int LEDI_RATE_MAX = 3;

    // Register addresses
    localparam logic [15:0] LEDI_ADDR_FORCE = 16'ha00b;
    localparam logic [15:0] LEDI_ADDR_LED_ONE = 16'ha00d;
    localparam logic [15:0] LEDI_ADDR_LED_TWO = 16'ha00e;
    localparam logic [15:0] LEDI_ADDR_BLINK = 16'ha00f;

    // Reset values
    localparam logic [15:0] LEDI_LED_CTRL_RST = 16'h0610;
    localparam logic [15:0] LEDI_FORCE_RST = 16'h0000;
    localparam logic [2:0] LEDI_DUTY_RST = 3'h0;
    localparam logic [1:0] LEDI_MODE_TWO_RATE_RST = 2'h1;
    localparam logic [1:0] LEDI_MODE_ONE_RATE_RST = 2'h2;

    // Per-LED behaviour control bits
    localparam int LEDI_B_SEL = 13;
    localparam int LEDI_B_FDX_ON = 12;
    localparam int LEDI_B_HDX_ON = 11;
    localparam int LEDI_B_TX_BLK = 10;
    localparam int LEDI_B_RX_BLK = 9;
    localparam int LEDI_B_TX_ON = 8;
    localparam int LEDI_B_RX_ON = 7;
    localparam int LEDI_B_GIG_ON = 6;
    localparam int LEDI_B_FAST_ON = 5;
    localparam int LEDI_B_TEN_ON = 4;
    localparam int LEDI_B_COL_BLK = 3;
    localparam int LEDI_B_GIG_BLK = 2;
    localparam int LEDI_B_FAST_BLK = 1;
    localparam int LEDI_B_TEN_BLK = 0;

    // Blink timing fields
    localparam int LEDI_DUTY_LSB = 4;
    localparam int LEDI_MODE_TWO_LSB = 2;
    localparam int LEDI_MODE_ONE_LSB = 0;

    // Force control fields
    localparam int LEDI_F1_EN = 5;
    localparam int LEDI_F1_MODE_LSB = 3;
    localparam int LEDI_F2_EN = 8;
    localparam int LEDI_F2_MODE_LSB = 6;
    localparam logic [1:0] LEDI_FRC_OFF = 2'h0;
    localparam logic [1:0] LEDI_FRC_ON = 2'h1;
    localparam logic [1:0] LEDI_FRC_BLINK_ONE = 2'h2;
    localparam logic [1:0] LEDI_FRC_BLINK_TWO = 2'h3;

    // Speed codes
    localparam logic [1:0] LEDI_SPD_TEN = 2'h0;
    localparam logic [1:0] LEDI_SPD_FAST = 2'h1;
    localparam logic [1:0] LEDI_SPD_GIG = 2'h2;

    // On slots out of twelve for each duty code
    localparam logic [7:0][3:0] LEDI_DUTY_ON = {4'h2, 4'h3, 4'h4, 4'h6,
                                                4'ha, 4'h9, 4'h8, 4'h6};

    typedef logic [15:0] ledi_word_t;

    typedef struct packed {
        logic link;
        logic [1:0] speed;
        logic full_duplex;
        logic tx_act;
        logic rx_act;
        logic collision;
    } ledi_phy_s;
endpackage : ledi_pkg
`default_nettype wire

// >>> hw/ledi_indicator.sv
// LED indicator control: two LED lanes, blink generator and registers.
// Assumes PHY status inputs come from logic on the same core clock.
//
// Overview of operation
// - Select bit: activity blinks always or if on
// - Full duplex enable lights LED steadily
// - Half duplex enable lights LED steadily
// - Transmit activity blinks at mode two rate
// - Receive activity blinks at mode two rate
// - Transmit activity holds LED on 10 ms
// - Receive activity holds LED on 10 ms
// - Speed-on bits light LED at matching speed
// - Collision blink bit blinks LED on collision
// - Speed-blink bits blink LED at matching speed
// - Any active blink overrides steady indication
// - Duty field sets blink on/off ratio
// - Mode two rate field, reset 4 Hz
// - Mode one rate field, reset 8 Hz
// - Force mode overrides normal indication
`timescale 1ns/10ps
`default_nettype none

module ledi_lane #(
    parameter int HOLD_CYC = ledi_pkg::LEDI_HOLD_CYC
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire ledi_pkg::ledi_word_t i_ctrl,
    input wire logic i_force_en,
    input wire logic [1:0] i_force_mode,
    input wire ledi_pkg::ledi_phy_s i_phy,
    input wire logic i_blink_one,
    input wire logic i_blink_two,
    output logic o_led
);
    localparam int HW = $clog2(HOLD_CYC + 1);
    localparam logic [HW-1:0] HOLD_LOAD = HW'(HOLD_CYC);

    logic [HW-1:0] hold_r;
    logic is_gig;
    logic is_fast;
    logic is_ten;
    logic on_cond;
    logic act_blk;
    logic oth_blk;
    logic hold_load;
    logic led_nxt;

    assign is_gig = i_phy.link && (i_phy.speed == ledi_pkg::LEDI_SPD_GIG);
    assign is_fast = i_phy.link && (i_phy.speed == ledi_pkg::LEDI_SPD_FAST);
    assign is_ten = i_phy.link && (i_phy.speed == ledi_pkg::LEDI_SPD_TEN);

    assign on_cond = i_phy.link &&
        ((i_ctrl[ledi_pkg::LEDI_B_FDX_ON] && i_phy.full_duplex) ||
         (i_ctrl[ledi_pkg::LEDI_B_HDX_ON] && !i_phy.full_duplex) ||
         (i_ctrl[ledi_pkg::LEDI_B_GIG_ON] && is_gig) ||
         (i_ctrl[ledi_pkg::LEDI_B_FAST_ON] && is_fast) ||
         (i_ctrl[ledi_pkg::LEDI_B_TEN_ON] && is_ten));

    assign act_blk = i_phy.link &&
        (i_ctrl[ledi_pkg::LEDI_B_SEL] || on_cond) &&
        ((i_ctrl[ledi_pkg::LEDI_B_TX_BLK] && i_phy.tx_act) ||
         (i_ctrl[ledi_pkg::LEDI_B_RX_BLK] && i_phy.rx_act));

    assign oth_blk = i_phy.link &&
        ((i_ctrl[ledi_pkg::LEDI_B_COL_BLK] && i_phy.collision) ||
         (i_ctrl[ledi_pkg::LEDI_B_GIG_BLK] && is_gig) ||
         (i_ctrl[ledi_pkg::LEDI_B_FAST_BLK] && is_fast) ||
         (i_ctrl[ledi_pkg::LEDI_B_TEN_BLK] && is_ten));

    assign hold_load = i_phy.link && !act_blk && !oth_blk &&
        ((i_ctrl[ledi_pkg::LEDI_B_TX_ON] && i_phy.tx_act) ||
         (i_ctrl[ledi_pkg::LEDI_B_RX_ON] && i_phy.rx_act));

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            hold_r <= '0;
        end else if (hold_load) begin
            hold_r <= HOLD_LOAD;
        end else if (hold_r != '0) begin
            hold_r <= hold_r - HW'(1);
        end
    end

    always_comb begin
        led_nxt = 1'b0;
        if (i_force_en) begin
            case (i_force_mode)
                ledi_pkg::LEDI_FRC_OFF: led_nxt = 1'b0;
                ledi_pkg::LEDI_FRC_ON: led_nxt = 1'b1;
                ledi_pkg::LEDI_FRC_BLINK_ONE: led_nxt = i_blink_one;
                ledi_pkg::LEDI_FRC_BLINK_TWO: led_nxt = i_blink_two;
                default: led_nxt = 1'b0;
            endcase
        end else if (act_blk) begin
            led_nxt = i_blink_two;
        end else if (oth_blk) begin
            led_nxt = i_blink_one;
        end else begin
            led_nxt = on_cond || hold_load || (i_phy.link && hold_r != '0);
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_led <= 1'b0;
        end else begin
            o_led <= led_nxt;
        end
    end

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_resetn);

    force_on_a: assert property (
        i_force_en && i_force_mode == ledi_pkg::LEDI_FRC_ON |=> o_led)
        else $error("forced on LED not lit");
    act_blink_a: assert property (
        !i_force_en && act_blk |=> o_led == $past(i_blink_two))
        else $error("activity blink not at mode two rate");
    oth_blink_a: assert property (
        !i_force_en && !act_blk && oth_blk |=> o_led == $past(i_blink_one))
        else $error("other blink not at mode one rate");
    fdx_on_a: assert property (
        !i_force_en && !act_blk && !oth_blk && i_phy.link &&
        i_phy.full_duplex && i_ctrl[ledi_pkg::LEDI_B_FDX_ON] |=> o_led)
        else $error("full duplex LED not lit");
    hdx_on_a: assert property (
        !i_force_en && !act_blk && !oth_blk && i_phy.link &&
        !i_phy.full_duplex && i_ctrl[ledi_pkg::LEDI_B_HDX_ON] |=> o_led)
        else $error("half duplex LED not lit");
    gig_on_a: assert property (
        !i_force_en && !act_blk && !oth_blk && is_gig &&
        i_ctrl[ledi_pkg::LEDI_B_GIG_ON] |=> o_led)
        else $error("gigabit LED not lit");
    hold_load_a: assert property (
        i_phy.link && i_phy.tx_act && i_ctrl[ledi_pkg::LEDI_B_TX_ON] &&
        !act_blk && !oth_blk |=> hold_r == HOLD_LOAD)
        else $error("activity hold not loaded");
    hold_keep_a: assert property (
        hold_r != '0 && i_phy.link && !i_force_en && !act_blk && !oth_blk
        |=> o_led)
        else $error("LED dropped during activity hold");
    select_off_a: assert property (
        !i_ctrl[ledi_pkg::LEDI_B_SEL] && !on_cond && !oth_blk &&
        !i_force_en && hold_r == '0 && !hold_load |=> !o_led)
        else $error("activity blinked while LED was off");
    blink_over_a: assert property (
        !i_force_en && act_blk && on_cond && !i_blink_two |=> !o_led)
        else $error("steady on overrode blink");
    rx_load_a: assert property (
        i_phy.link && i_phy.rx_act && i_ctrl[ledi_pkg::LEDI_B_RX_ON] &&
        !act_blk && !oth_blk |=> hold_r == HOLD_LOAD)
        else $error("receive hold not loaded");
    force_off_a: assert property (
        i_force_en && i_force_mode == ledi_pkg::LEDI_FRC_OFF |=> !o_led)
        else $error("forced off LED lit");
    force_blink_a: assert property (
        i_force_en && i_force_mode == ledi_pkg::LEDI_FRC_BLINK_ONE |=>
        o_led == $past(i_blink_one))
        else $error("forced blink not at mode one rate");
    link_down_a: assert property (
        !i_force_en && !i_phy.link |=> !o_led)
        else $error("LED lit with link down");

    act_blink_c: cover property (act_blk ##1 o_led ##1 !o_led);
    hold_end_c: cover property (hold_r == HW'(1) ##2 !o_led);
    force_c: cover property (i_force_en ##1 o_led);
endmodule : ledi_lane

module ledi_indicator #(
    parameter int HOLD_CYC = ledi_pkg::LEDI_HOLD_CYC,
    parameter int TICK_CYC = ledi_pkg::LEDI_TICK_CYC
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic [15:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire ledi_pkg::ledi_phy_s i_phy,
    output logic [15:0] o_rdata,
    output logic o_led_one,
    output logic o_led_two
);
    localparam int TW = $clog2(TICK_CYC);
    localparam int PW = $clog2(ledi_pkg::LEDI_PHASE_N);
    localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYC - 1);
    localparam logic [PW-1:0] PHASE_LAST = PW'(ledi_pkg::LEDI_PHASE_N - 1);
    localparam logic [PW-1:0] SLOTS = PW'(ledi_pkg::LEDI_SLOTS_N);

    ledi_pkg::ledi_word_t ctrl_one_r;
    ledi_pkg::ledi_word_t ctrl_two_r;
    ledi_pkg::ledi_word_t force_r;
    logic [2:0] duty_r;
    logic [1:0] rate_two_r;
    logic [1:0] rate_one_r;
    logic [TW-1:0] tick_r;
    logic [PW-1:0] phase_r;
    logic blink_one_r;
    logic blink_two_r;
    logic [15:0] rdata_nxt;
    logic [15:0] blink_word;

    assign blink_word = {9'h000, duty_r, rate_two_r, rate_one_r};

    // Register writes
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ctrl_one_r <= ledi_pkg::LEDI_LED_CTRL_RST;
            ctrl_two_r <= ledi_pkg::LEDI_LED_CTRL_RST;
            force_r <= ledi_pkg::LEDI_FORCE_RST;
        end else if (i_wr) begin
            case (i_addr)
                ledi_pkg::LEDI_ADDR_LED_ONE: ctrl_one_r <= i_wdata;
                ledi_pkg::LEDI_ADDR_LED_TWO: ctrl_two_r <= i_wdata;
                ledi_pkg::LEDI_ADDR_FORCE: force_r <= i_wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            duty_r <= ledi_pkg::LEDI_DUTY_RST;
            rate_two_r <= ledi_pkg::LEDI_MODE_TWO_RATE_RST;
            rate_one_r <= ledi_pkg::LEDI_MODE_ONE_RATE_RST;
        end else if (i_wr && i_addr == ledi_pkg::LEDI_ADDR_BLINK) begin
            duty_r <= i_wdata[ledi_pkg::LEDI_DUTY_LSB +: 3];
            rate_two_r <= i_wdata[ledi_pkg::LEDI_MODE_TWO_LSB +: 2];
            rate_one_r <= i_wdata[ledi_pkg::LEDI_MODE_ONE_LSB +: 2];
        end
    end

    // Register reads, data one cycle later
    always_comb begin
        case (i_addr)
            ledi_pkg::LEDI_ADDR_LED_ONE: rdata_nxt = ctrl_one_r;
            ledi_pkg::LEDI_ADDR_LED_TWO: rdata_nxt = ctrl_two_r;
            ledi_pkg::LEDI_ADDR_FORCE: rdata_nxt = force_r;
            ledi_pkg::LEDI_ADDR_BLINK: rdata_nxt = blink_word;
            default: rdata_nxt = 16'h0000;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rdata <= 16'h0000;
        end else if (i_rd) begin
            o_rdata <= rdata_nxt;
        end else begin
            o_rdata <= 16'h0000;
        end
    end

    // Slot tick and blink phase from the core clock
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            tick_r <= '0;
            phase_r <= '0;
        end else if (tick_r == TICK_LAST) begin
            tick_r <= '0;
            phase_r <= (phase_r == PHASE_LAST) ? '0 : phase_r + PW'(1);
        end else begin
            tick_r <= tick_r + TW'(1);
        end
    end

    function automatic logic blink_level(input logic [PW-1:0] phase,
                                         input logic [1:0] rate,
                                         input logic [2:0] duty);
        logic [PW-1:0] slot;
        slot = (phase >> (2'(ledi_pkg::LEDI_RATE_MAX) - rate)) % SLOTS;
        blink_level = slot < PW'(ledi_pkg::LEDI_DUTY_ON[duty]);
    endfunction : blink_level

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            blink_one_r <= 1'b0;
            blink_two_r <= 1'b0;
        end else begin
            blink_one_r <= blink_level(phase_r, rate_one_r, duty_r);
            blink_two_r <= blink_level(phase_r, rate_two_r, duty_r);
        end
    end

    ledi_lane #(
        .HOLD_CYC(HOLD_CYC)
    ) u_lane_one (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_ctrl(ctrl_one_r),
        .i_force_en(force_r[ledi_pkg::LEDI_F1_EN]),
        .i_force_mode(force_r[ledi_pkg::LEDI_F1_MODE_LSB +: 2]),
        .i_phy(i_phy),
        .i_blink_one(blink_one_r),
        .i_blink_two(blink_two_r),
        .o_led(o_led_one)
    );

    ledi_lane #(
        .HOLD_CYC(HOLD_CYC)
    ) u_lane_two (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_ctrl(ctrl_two_r),
        .i_force_en(force_r[ledi_pkg::LEDI_F2_EN]),
        .i_force_mode(force_r[ledi_pkg::LEDI_F2_MODE_LSB +: 2]),
        .i_phy(i_phy),
        .i_blink_one(blink_one_r),
        .i_blink_two(blink_two_r),
        .o_led(o_led_two)
    );

    blink_read_a: assert property (
        @(posedge i_clk) disable iff (!i_resetn)
        i_rd && i_addr == ledi_pkg::LEDI_ADDR_BLINK |=>
        o_rdata == $past(blink_word) && o_rdata[15:7] == 9'h000)
        else $error("blink timing readback wrong");
    half_duty_a: assert property (
        @(posedge i_clk) disable iff (!i_resetn)
        duty_r[1:0] == 2'h0 && tick_r == '0 &&
        (phase_r % SLOTS) == PW'(ledi_pkg::LEDI_SLOTS_N / 2) &&
        rate_two_r == 2'(ledi_pkg::LEDI_RATE_MAX) |=> !blink_two_r)
        else $error("half duty wave not off at midpoint");
    rdata_idle_a: assert property (
        @(posedge i_clk) disable iff (!i_resetn)
        !i_rd |=> o_rdata == 16'h0000)
        else $error("read data not cleared after read");

    blink_two_c: cover property (@(posedge i_clk) disable iff (!i_resetn)
        $rose(blink_two_r));
    read_c: cover property (@(posedge i_clk) disable iff (!i_resetn)
        i_rd ##1 o_rdata != 16'h0000);
endmodule : ledi_indicator
`default_nettype wire

// >>> tb/ledi_led_model.sv
// Board LED model: tallies lit cycles and turn-on events of one LED.
// Assumes the LED pin is sampled on the rising edge of the core clock.
`timescale 1ns/10ps
`default_nettype none
module ledi_led_model (
    input wire logic i_clk,
    input wire logic i_led,
    input wire logic i_clear,
    output var int o_lit,
    output var int o_rises
);
    logic prev_r;

    // Lit time and rises
    always_ff @(posedge i_clk) begin
        prev_r <= i_led;
        if (i_clear) begin
            o_lit <= 0;
            o_rises <= 0;
        end else begin
            o_lit <= o_lit + int'(i_led);
            o_rises <= o_rises + int'(i_led & ~prev_r);
        end
    end
endmodule : ledi_led_model
`default_nettype wire

// >>> tb/ledi_indicator_bench.sv
// Testbench of the LED indicator: register calls and LED measurements.
// Assumes shortened hold and tick counts; windows of 384 cycles.
`timescale 1ns/10ps
`default_nettype none
module ledi_indicator_bench;
    logic clk;
    logic resetn;
    logic wr;
    logic rd;
    logic clr;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic led1;
    logic led2;
    ledi_pkg::ledi_phy_s phy;
    int lit1, lit2, rise1, rise2;
    int bad_count;
    int comparisons;
    int on_slots [8] = '{6, 8, 9, 10, 6, 4, 3, 2};

    ledi_indicator #(.HOLD_CYC(20), .TICK_CYC(4)) dut (
        .i_clk(clk),
        .i_resetn(resetn),
        .i_addr(addr),
        .i_wdata(wdata),
        .i_wr(wr),
        .i_rd(rd),
        .i_phy(phy),
        .o_rdata(rdata),
        .o_led_one(led1),
        .o_led_two(led2)
    );
    ledi_led_model m_one (.i_clk(clk), .i_led(led1), .i_clear(clr),
        .o_lit(lit1), .o_rises(rise1));
    ledi_led_model m_two (.i_clk(clk), .i_led(led2), .i_clear(clr),
        .o_lit(lit2), .o_rises(rise2));

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : conclude

    task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : cmp_word

    task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        cmp_word(rdata, exp);
        @(negedge clk);
        cmp_word(rdata, 16'h0000);
    endtask : rd_chk

    task automatic setp(input logic [6:0] v);
        @(posedge clk);
        phy <= ledi_pkg::ledi_phy_s'(v);
    endtask : setp

    // Window of 384 cycles, optional one-cycle status pulse at its start
    task automatic meas(input int lane, input logic [6:0] act,
                        input int exp_lit, input int exp_rise, input int tol);
        ledi_pkg::ledi_phy_s base;
        int l;
        repeat (8) @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        base = phy;
        phy <= ledi_pkg::ledi_phy_s'(base | act);
        @(posedge clk);
        phy <= base;
        repeat (383) @(posedge clk);
        @(negedge clk);
        l = (lane != 0) ? lit2 : lit1;
        cmp_word(16'(l >= exp_lit && l <= exp_lit + tol), 16'h1);
        cmp_word(16'((lane != 0) ? rise2 : rise1), 16'(exp_rise));
    endtask : meas

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    initial begin
        #1ms;
        bad_count++;
        conclude();
    end

    initial begin
        resetn = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        clr = 1'b0;
        addr = 16'h0000;
        wdata = 16'h0000;
        phy = '0;
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        rd_chk(16'ha00d, 16'h0610);
        rd_chk(16'ha00e, 16'h0610);
        rd_chk(16'ha00f, 16'h0006);
        rd_chk(16'ha00b, 16'h0000);
        wr_reg(16'ha010, 16'hffff);
        rd_chk(16'ha010, 16'h0000);
        wr_reg(16'ha00f, 16'hffff);
        rd_chk(16'ha00f, 16'h007f);
        wr_reg(16'ha00e, 16'hffff);
        rd_chk(16'ha00e, 16'hffff);
        $display("test registers done");
        wr_reg(16'ha00f, 16'h0003);
        for (int s = 0; s < 3; s++) begin
            wr_reg(16'ha00d, 16'h1 << (4 + s));
            setp({1'b1, 2'(s), 4'h0});
            meas(0, 7'h00, 384, 0, 0);
            setp({1'b1, 2'((s + 1) % 3), 4'h0});
            meas(0, 7'h00, 0, 0, 0);
            wr_reg(16'ha00d, 16'h1 << s);
            setp({1'b1, 2'(s), 4'h0});
            meas(0, 7'h00, 192, 8, 0);
        end
        wr_reg(16'ha00d, 16'h1000);
        setp(7'h48);
        meas(0, 7'h00, 384, 0, 0);
        setp(7'h40);
        meas(0, 7'h00, 0, 0, 0);
        wr_reg(16'ha00d, 16'h0800);
        meas(0, 7'h00, 384, 0, 0);
        setp(7'h00);
        meas(0, 7'h00, 0, 0, 0);
        $display("test steady done");
        wr_reg(16'ha00d, 16'h0044);
        setp(7'h60);
        for (int r = 0; r < 4; r++) begin
            wr_reg(16'ha00f, 16'(r));
            meas(0, 7'h00, 192, 1 << r, 0);
        end
        for (int d = 0; d < 8; d++) begin
            wr_reg(16'ha00f, 16'((d << 4) | 3));
            meas(0, 7'h00, 32 * on_slots[d], 8, 0);
        end
        $display("test blink done");
        wr_reg(16'ha00f, 16'h000c);
        wr_reg(16'ha00d, 16'h0440);
        setp(7'h64);
        meas(0, 7'h00, 192, 8, 0);
        wr_reg(16'ha00d, 16'h0240);
        setp(7'h62);
        meas(0, 7'h00, 192, 8, 0);
        wr_reg(16'ha00d, 16'h0200);
        meas(0, 7'h00, 0, 0, 0);
        for (int r = 0; r < 4; r++) begin
            wr_reg(16'ha00f, 16'(r << 2));
            wr_reg(16'ha00d, 16'h2200);
            meas(0, 7'h00, 192, 1 << r, 0);
        end
        wr_reg(16'ha00d, 16'h0008);
        setp(7'h61);
        meas(0, 7'h00, 192, 1, 0);
        setp(7'h60);
        meas(0, 7'h00, 0, 0, 0);
        $display("test activity done");
        wr_reg(16'ha00d, 16'h0100);
        meas(0, 7'h04, 20, 1, 2);
        wr_reg(16'ha00d, 16'h0080);
        meas(0, 7'h02, 20, 1, 2);
        setp(7'h40);
        wr_reg(16'ha00e, 16'h0610);
        meas(1, 7'h00, 384, 0, 0);
        setp(7'h00);
        wr_reg(16'ha00b, 16'h0028);
        meas(0, 7'h00, 384, 0, 0);
        wr_reg(16'ha00b, 16'h01c0);
        meas(1, 7'h00, 192, 8, 0);
        wr_reg(16'ha00d, 16'h0040);
        setp(7'h60);
        wr_reg(16'ha00b, 16'h0020);
        meas(0, 7'h00, 0, 0, 0);
        wr_reg(16'ha00b, 16'h0030);
        meas(0, 7'h00, 192, 1, 0);
        @(posedge clk);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        rd_chk(16'ha00b, 16'h0000);
        rd_chk(16'ha00f, 16'h0006);
        $display("test hold and force done");
        conclude();
    end
endmodule : ledi_indicator_bench
`default_nettype wire
